// >>> hdl/shp_cfg.svh
// shp_cfg.svh: parser constants.
// assumes: included by bare name.
`ifndef SHP_CFG_SVH
`define SHP_CFG_SVH

// timing
`define SHP_CLK_HZ 50000000
`define SHP_INT_BAUD 460800
`define SHP_BAUD_9600 9600
`define SHP_BAUD_19200 19200
`define SHP_BAUD_38400 38400
`define SHP_BAUD_57600 57600
`define SHP_BAUD_115200 115200

// register offsets
`define SHP_REG_CTRL 4'h0
`define SHP_REG_STAT 4'h4
`define SHP_REG_LAST 4'h8

// control fields and reset values
`define SHP_CTRL_ADDR 4:0
`define SHP_CTRL_RATE 7:5
`define SHP_ADDR_RST 5'h01
`define SHP_RATE_RST 3'h4
`define SHP_RATE_9600 3'h0
`define SHP_RATE_19200 3'h1
`define SHP_RATE_38400 3'h2
`define SHP_RATE_57600 3'h3

// status fields
`define SHP_ST_CMDERR 0
`define SHP_ST_QINT 1
`define SHP_ST_ARMED 2
`define SHP_ST_TXFULL 3
`define SHP_ST_LEVEL 8:4

// characters
`define SHP_CH_NL 8'h0A
`define SHP_CH_COLON 8'h3A
`define SHP_CH_SEMI 8'h3B
`define SHP_CH_SPACE 8'h20
`define SHP_CH_QMARK 8'h3F
`define SHP_CH_STAR 8'h2A
`define SHP_CH_LA 8'h61
`define SHP_CH_LZ 8'h7A
`define SHP_CASE_OFS 8'h20
`define SHP_KEY_BLANK 32'h20202020
`define SHP_KEY_MAX 3'h4
`define SHP_KCNT_SAT 3'h7

// tree nodes
`define SHP_N_ROOT 5'h00
`define SHP_N_SOUR 5'h01
`define SHP_N_VOLT 5'h02
`define SHP_N_VLEV 5'h03
`define SHP_N_VRNG 5'h04
`define SHP_N_FREQ 5'h05
`define SHP_N_CURR 5'h06
`define SHP_N_CLEV 5'h07
`define SHP_N_CPRO 5'h08
`define SHP_N_CPST 5'h09
`define SHP_N_OUTP 5'h0A
`define SHP_N_OSTA 5'h0B
`define SHP_N_FUNC 5'h0C
`define SHP_N_PHAS 5'h0D
`define SHP_N_PULS 5'h0E
`define SHP_N_LIST 5'h0F
`define SHP_N_COUNT 16
`define SHP_N_NONE 5'h1F

// short-form keys, upper case, blank padded
`define SHP_K_SOUR 32'h534F5552
`define SHP_K_VOLT 32'h564F4C54
`define SHP_K_LEV 32'h4C455620
`define SHP_K_RANG 32'h52414E47
`define SHP_K_FREQ 32'h46524551
`define SHP_K_CURR 32'h43555252
`define SHP_K_PROT 32'h50524F54
`define SHP_K_STAT 32'h53544154
`define SHP_K_OUTP 32'h4F555450
`define SHP_K_FUNC 32'h46554E43
`define SHP_K_PHAS 32'h50484153
`define SHP_K_PUL 32'h50554C20
`define SHP_K_LIST 32'h4C495354

`endif

// >>> hdl/shp_pkg.sv
// shp_pkg: parser types.
// assumes: compiled before the parser modules.
package shp_pkg;

	typedef enum logic [1:0] {SHP_PORT_BUS, SHP_PORT_USB, SHP_PORT_LAN, SHP_PORT_SER} shp_port_t;

	typedef enum {SHP_UNIT, SHP_HDR, SHP_PARAM, SHP_SKIP, SHP_COMMON} shp_state_t;

	typedef struct packed {
		shp_port_t port;
		logic end_ind;
		logic [7:0] data;
	} shp_rx_t;

	typedef struct packed {
		logic [4:0] node;
		logic query;
	} shp_cmd_t;

	typedef struct packed {
		logic last;
		logic [7:0] data;
	} shp_resp_t;

	typedef struct packed {
		logic [31:0] key;
		logic short3;
		logic [4:0] parent;
		logic leaf;
		logic [4:0] dflt;
	} shp_node_t;

endpackage

// >>> hdl/shp_tree_lookup.sv
// shp_tree_lookup: command tree search for one key.
// assumes: key upper case, blank padded.
`timescale 1ns/100ps
`include "shp_cfg.svh"
module shp_tree_lookup (
	input wire logic [4:0] level,
	input wire logic [31:0] key,
	output logic found,
	output shp_pkg::shp_node_t hit,
	output logic [4:0] hit_idx
);

	// node table: key, 3-letter short form, parent, leaf, default child
	function automatic shp_pkg::shp_node_t node_rec(input logic [4:0] idx);
		shp_pkg::shp_node_t r;
		case (idx)
			`SHP_N_SOUR: r = '{`SHP_K_SOUR, 1'b0, `SHP_N_ROOT, 1'b0, `SHP_N_NONE};
			`SHP_N_VOLT: r = '{`SHP_K_VOLT, 1'b0, `SHP_N_SOUR, 1'b0, `SHP_N_VLEV};
			`SHP_N_VLEV: r = '{`SHP_K_LEV, 1'b1, `SHP_N_VOLT, 1'b1, `SHP_N_NONE};
			`SHP_N_VRNG: r = '{`SHP_K_RANG, 1'b0, `SHP_N_VOLT, 1'b1, `SHP_N_NONE};
			`SHP_N_FREQ: r = '{`SHP_K_FREQ, 1'b0, `SHP_N_SOUR, 1'b1, `SHP_N_NONE};
			`SHP_N_CURR: r = '{`SHP_K_CURR, 1'b0, `SHP_N_SOUR, 1'b0, `SHP_N_CLEV};
			`SHP_N_CLEV: r = '{`SHP_K_LEV, 1'b1, `SHP_N_CURR, 1'b1, `SHP_N_NONE};
			`SHP_N_CPRO: r = '{`SHP_K_PROT, 1'b0, `SHP_N_CURR, 1'b0, `SHP_N_CPST};
			`SHP_N_CPST: r = '{`SHP_K_STAT, 1'b0, `SHP_N_CPRO, 1'b1, `SHP_N_NONE};
			`SHP_N_OUTP: r = '{`SHP_K_OUTP, 1'b0, `SHP_N_ROOT, 1'b0, `SHP_N_OSTA};
			`SHP_N_OSTA: r = '{`SHP_K_STAT, 1'b0, `SHP_N_OUTP, 1'b1, `SHP_N_NONE};
			`SHP_N_FUNC: r = '{`SHP_K_FUNC, 1'b0, `SHP_N_SOUR, 1'b1, `SHP_N_NONE};
			`SHP_N_PHAS: r = '{`SHP_K_PHAS, 1'b0, `SHP_N_SOUR, 1'b1, `SHP_N_NONE};
			`SHP_N_PULS: r = '{`SHP_K_PUL, 1'b1, `SHP_N_SOUR, 1'b1, `SHP_N_NONE};
			`SHP_N_LIST: r = '{`SHP_K_LIST, 1'b0, `SHP_N_SOUR, 1'b1, `SHP_N_NONE};
			default: r = '{`SHP_KEY_BLANK, 1'b0, `SHP_N_NONE, 1'b0, `SHP_N_NONE};
		endcase
		return r;
	endfunction

	// first matching child of the active level; at the root the optional
	// source level is searched too, nothing else (no tree walking)
	always_comb
	begin
		shp_pkg::shp_node_t r;
		logic key_ok;
		logic lvl_ok;
		r = '0;
		key_ok = 1'b0;
		lvl_ok = 1'b0;
		found = 1'b0;
		hit = '0;
		hit_idx = `SHP_N_NONE;
		for (int i = 1; i < `SHP_N_COUNT; i++)
		begin
			r = node_rec(5'(i));
			key_ok = r.short3 ? (key[31:8] == r.key[31:8]) : (key == r.key);
			lvl_ok = (r.parent == level) ||
				((level == `SHP_N_ROOT) && (r.parent == `SHP_N_SOUR)); // R9 R11
			if (key_ok && lvl_ok && !found)
			begin
				found = 1'b1;
				hit = r;
				hit_idx = 5'(i);
			end
		end
	end

endmodule

// >>> hdl/shp_header_parser.sv
// shp_header_parser: program message parser with active header path,
// response gate, bus address, baud ticks and register port.
// assumes: inputs synchronous to core_clk; one byte per valid cycle.
`timescale 1ns/100ps
`include "shp_cfg.svh"
// Behaviour
// [R1] path at root after reset and device clear
// [R2] message terminator returns path to root
// [R3] leading colon resets path to root
// [R4] non-leaf header moves path down one level
// [R5] headers must be colon separated by controller
// [R6] after leaf, path stays at leaf's level
// [R7] omitted optional headers are inferred as present
// [R8] omitted trailing leaf sets path one level higher
// [R9] source subsystems accepted as root-level headers
// [R10] common commands leave active path unchanged
// [R11] no enhanced tree walking
// [R12] program messages accepted at any time
// [R13] responses sent only after a query
// [R14] one bus address, set by panel or command
// [R15] controller uses new address after change
// [R16] usb and lan use fixed internal rate
// [R17] serial port has selectable baud rates
// [R18] attention, trigger, service request only on bus
// [R19] header match ignores letter case
// [R20] newline or end indication terminates message
// [R21] new command over unread response: error, discard
// [R22] unresolved header: error, skip rest of unit
module shp_header_parser #(
	parameter int CLK_HZ = `SHP_CLK_HZ,
	parameter int INT_BAUD = `SHP_INT_BAUD
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic dev_clear,
	input wire logic rx_valid,
	input wire shp_pkg::shp_rx_t rx,
	output logic rx_ready,
	output logic cmd_valid,
	output shp_pkg::shp_cmd_t cmd,
	output logic common_valid,
	output logic cmd_error,
	input wire logic resp_in_valid,
	input wire shp_pkg::shp_resp_t resp_in,
	output logic resp_in_ready,
	output logic tx_valid,
	output shp_pkg::shp_resp_t tx,
	input wire logic tx_ready,
	input wire logic bus_addr_valid,
	input wire logic [4:0] bus_addr_in,
	output logic addr_hit,
	input wire logic fp_addr_we,
	input wire logic [4:0] fp_addr,
	output logic [4:0] bus_addr,
	input wire logic get_in,
	input wire logic srq_req,
	output logic trig_pulse,
	output logic srq_out,
	output logic int_baud_tick,
	output logic ser_baud_tick,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata
);

	localparam logic [12:0] INT_DIV = 13'(CLK_HZ / INT_BAUD);
	localparam logic [12:0] DIV_9600 = 13'(CLK_HZ / `SHP_BAUD_9600);
	localparam logic [12:0] DIV_19200 = 13'(CLK_HZ / `SHP_BAUD_19200);
	localparam logic [12:0] DIV_38400 = 13'(CLK_HZ / `SHP_BAUD_38400);
	localparam logic [12:0] DIV_57600 = 13'(CLK_HZ / `SHP_BAUD_57600);
	localparam logic [12:0] DIV_115200 = 13'(CLK_HZ / `SHP_BAUD_115200);

	shp_pkg::shp_state_t state;
	shp_pkg::shp_state_t next_state;
	logic [4:0] level;
	logic [4:0] next_level;
	logic [31:0] key;
	logic [2:0] kcnt;
	logic msg_idle;
	logic armed;
	logic tx_full;
	logic err_cmd;
	logic err_qint;
	logic [4:0] addr_reg;
	logic [2:0] rate_sel;
	shp_pkg::shp_port_t act_port;
	logic [12:0] int_cnt;
	logic [12:0] ser_cnt;
	logic [12:0] ser_div;

	// character classes; lower case folded so any case mix matches
	wire logic [7:0] ch = rx.data;
	wire logic is_lower = (ch >= `SHP_CH_LA) && (ch <= `SHP_CH_LZ);
	wire logic [7:0] ch_up = is_lower ? ch - `SHP_CASE_OFS : ch; // R19
	wire logic is_nl = ch == `SHP_CH_NL;
	wire logic is_colon = ch == `SHP_CH_COLON;
	wire logic is_semi = ch == `SHP_CH_SEMI;
	wire logic is_space = ch == `SHP_CH_SPACE;
	wire logic is_q = ch == `SHP_CH_QMARK;
	wire logic is_star = ch == `SHP_CH_STAR;
	wire logic plain = !(is_nl | is_colon | is_semi | is_space | is_q | is_star);
	wire logic term = rx_valid && (is_nl || rx.end_ind); // R20
	wire logic in_unit = state == shp_pkg::SHP_UNIT;
	wire logic in_hdr = state == shp_pkg::SHP_HDR;

	// header open, or a plain byte that also ends the message
	wire logic hdr_now = in_hdr || (in_unit && plain);
	wire logic add_char = rx_valid && plain && (in_hdr || in_unit);
	wire logic [5:0] kshift = {kcnt, 3'b000};
	wire logic [31:0] key_mask = 32'hFF000000 >> kshift;
	wire logic [31:0] key_add = (key & ~key_mask) | ({ch_up, 24'h000000} >> kshift);
	wire logic [31:0] key_look = (add_char && kcnt < `SHP_KEY_MAX) ? key_add : key;

	wire logic found;
	shp_pkg::shp_node_t hit;
	wire logic [4:0] hit_idx;

	shp_tree_lookup u_lookup (
		.level(level),
		.key(key_look),
		.found(found),
		.hit(hit),
		.hit_idx(hit_idx)
	);

	// resolution of the open header at a separator
	wire logic resolve = rx_valid && hdr_now && (is_colon || is_semi || is_space || is_q || term);
	wire logic descend = resolve && is_colon;
	wire logic finalize = resolve && !is_colon;
	wire logic no_dflt = !hit.leaf && (hit.dflt == `SHP_N_NONE);
	// glued headers match on their first four letters, or first three for 3-letter short forms, and fall here by the same rules as the header matched
	wire logic bad_hdr = resolve && (!found || (descend && hit.leaf) || (finalize && no_dflt)); // R5 R22
	wire logic bad_start = rx_valid && in_unit && is_q && !term;
	wire logic good_cmd = finalize && !bad_hdr;
	wire logic [4:0] cmd_node = hit.leaf ? hit_idx : hit.dflt; // R7

	// a new message over an unread response interrupts it
	wire logic msg_start = rx_valid && msg_idle && in_unit && !is_space && !is_nl;
	wire logic qint = msg_start && (armed || tx_full); // R21

	// response holding stage
	wire logic resp_take = resp_in_valid && !tx_full;
	wire logic tx_load = resp_take && armed; // R13
	wire logic tx_pop = tx_full && tx_ready;

	// register decode
	wire logic wr_ctrl = reg_wr && (reg_addr == `SHP_REG_CTRL);
	wire logic wr_stat = reg_wr && (reg_addr == `SHP_REG_STAT);
	wire logic [31:0] ctrl_word = {24'h000000, rate_sel, addr_reg};
	wire logic [31:0] stat_word = {23'h000000, level, tx_full, armed, err_qint, err_cmd};
	wire logic [31:0] last_word = {26'h0000000, cmd};
	wire logic [31:0] rd_mux = (reg_addr == `SHP_REG_CTRL) ? ctrl_word :
		(reg_addr == `SHP_REG_STAT) ? stat_word :
		(reg_addr == `SHP_REG_LAST) ? last_word : 32'h00000000;

	assign rx_ready = 1'b1; // R12
	assign resp_in_ready = !tx_full;
	assign tx_valid = tx_full;
	assign bus_addr = addr_reg;

	// next path level and parser state
	always_comb
	begin
		next_level = level;
		next_state = state;
		if (term)
		begin
			next_level = `SHP_N_ROOT; // R2
			next_state = shp_pkg::SHP_UNIT;
		end
		else if (rx_valid)
		begin
			unique case (state)
				shp_pkg::SHP_UNIT:
				begin
					if (is_colon)
					begin
						next_level = `SHP_N_ROOT; // R3
						next_state = shp_pkg::SHP_HDR;
					end
					else if (is_star)
						next_state = shp_pkg::SHP_COMMON; // R10
					else if (is_q)
						next_state = shp_pkg::SHP_SKIP;
					else if (plain)
						next_state = shp_pkg::SHP_HDR;
				end
				shp_pkg::SHP_HDR:
				begin
					if (bad_hdr)
						next_state = shp_pkg::SHP_SKIP; // R22
					else if (descend)
						next_level = hit_idx; // R4
					else if (finalize)
					begin
						// leaf stays among siblings; omitted leaf goes one level up
						next_level = hit.parent; // R6 R8
						next_state = is_semi ? shp_pkg::SHP_UNIT : shp_pkg::SHP_PARAM;
					end
				end
				shp_pkg::SHP_PARAM, shp_pkg::SHP_SKIP, shp_pkg::SHP_COMMON:
				begin
					if (is_semi)
						next_state = shp_pkg::SHP_UNIT;
				end
			endcase
		end
	end

	// parser registers; device clear wins over the byte stream
	always_ff @(posedge core_clk)
	begin
		if (!rst_n || dev_clear)
		begin
			state <= shp_pkg::SHP_UNIT;
			level <= `SHP_N_ROOT; // R1
			key <= `SHP_KEY_BLANK;
			kcnt <= 3'h0;
			msg_idle <= 1'b1;
		end
		else
		begin
			state <= next_state;
			level <= next_level;
			if (resolve || next_state != shp_pkg::SHP_HDR)
			begin
				key <= `SHP_KEY_BLANK;
				kcnt <= 3'h0;
			end
			else if (add_char)
			begin
				key <= key_look;
				kcnt <= (kcnt == `SHP_KCNT_SAT) ? kcnt : kcnt + 3'h1;
			end
			if (term)
				msg_idle <= 1'b1;
			else if (msg_start)
				msg_idle <= 1'b0;
		end
	end

	// command strobes, one cycle after the separator byte, or after the star for common_valid
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			cmd_valid <= 1'b0;
			cmd <= '0;
			common_valid <= 1'b0;
			cmd_error <= 1'b0;
		end
		else
		begin
			cmd_valid <= good_cmd && !dev_clear;
			if (good_cmd)
				cmd <= '{cmd_node, is_q};
			common_valid <= rx_valid && in_unit && is_star && !dev_clear; // R10
			cmd_error <= (bad_hdr || bad_start) && !dev_clear;
		end
	end

	// response gate: armed by a query, discarded when interrupted or cleared
	always_ff @(posedge core_clk)
	begin
		if (!rst_n || dev_clear)
		begin
			armed <= 1'b0;
			tx_full <= 1'b0;
			tx <= '0;
		end
		else
		begin
			if (good_cmd && is_q)
				armed <= 1'b1; // R13
			else if (qint || (tx_pop && tx.last))
				armed <= 1'b0; // R21
			if (qint)
				tx_full <= 1'b0; // R21
			else if (tx_load)
				tx_full <= 1'b1;
			else if (tx_pop)
				tx_full <= 1'b0;
			if (tx_load)
				tx <= resp_in;
		end
	end

	// sticky errors, write one clears, a new event wins
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			err_cmd <= 1'b0;
			err_qint <= 1'b0;
		end
		else
		begin
			err_cmd <= (bad_hdr || bad_start) || (err_cmd && !(wr_stat && reg_wdata[`SHP_ST_CMDERR]));
			err_qint <= qint || (err_qint && !(wr_stat && reg_wdata[`SHP_ST_QINT])); // R21
		end
	end

	// control register; a bus write beats the panel
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			addr_reg <= `SHP_ADDR_RST;
			rate_sel <= `SHP_RATE_RST;
			reg_rdata <= 32'h00000000;
			addr_hit <= 1'b0;
		end
		else
		begin
			if (wr_ctrl)
			begin
				addr_reg <= reg_wdata[`SHP_CTRL_ADDR]; // R14
				rate_sel <= reg_wdata[`SHP_CTRL_RATE]; // R17
			end
			else if (fp_addr_we)
				addr_reg <= fp_addr; // R14
			reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
			addr_hit <= bus_addr_valid && (bus_addr_in == addr_reg); // R14
		end
	end

	// bus-only events follow the last byte's port
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			act_port <= shp_pkg::SHP_PORT_BUS;
			trig_pulse <= 1'b0;
			srq_out <= 1'b0;
		end
		else
		begin
			if (rx_valid)
				act_port <= rx.port;
			trig_pulse <= get_in && (act_port == shp_pkg::SHP_PORT_BUS); // R18
			srq_out <= srq_req && (act_port == shp_pkg::SHP_PORT_BUS); // R18
		end
	end

	// serial divisor; unused codes fall back to the fastest rate
	assign ser_div = (rate_sel == `SHP_RATE_9600) ? DIV_9600 :
		(rate_sel == `SHP_RATE_19200) ? DIV_19200 :
		(rate_sel == `SHP_RATE_38400) ? DIV_38400 :
		(rate_sel == `SHP_RATE_57600) ? DIV_57600 : DIV_115200; // R17

	// baud ticks: fixed internal rate, and serial rate selected by rate_sel
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			int_cnt <= 13'h0000;
			ser_cnt <= 13'h0000;
			int_baud_tick <= 1'b0;
			ser_baud_tick <= 1'b0;
		end
		else
		begin
			int_baud_tick <= int_cnt == INT_DIV - 13'h0001; // R16
			int_cnt <= (int_cnt >= INT_DIV - 13'h0001) ? 13'h0000 : int_cnt + 13'h0001;
			ser_baud_tick <= ser_cnt == ser_div - 13'h0001;
			ser_cnt <= (ser_cnt >= ser_div - 13'h0001) ? 13'h0000 : ser_cnt + 13'h0001;
		end
	end

endmodule

// >>> testbench/shp_header_parser_properties.sv
// shp_header_parser_properties: port checks of the parser.
// assumes: bound to shp_header_parser.
`timescale 1ns/100ps
`include "shp_cfg.svh"
module shp_header_parser_properties #(
	parameter int CLK_HZ = `SHP_CLK_HZ,
	parameter int INT_BAUD = `SHP_INT_BAUD
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic dev_clear,
	input wire logic rx_valid,
	input wire shp_pkg::shp_rx_t rx,
	input wire logic cmd_valid,
	input wire shp_pkg::shp_cmd_t cmd,
	input wire logic common_valid,
	input wire logic cmd_error,
	input wire logic tx_valid,
	input wire shp_pkg::shp_resp_t tx,
	input wire logic tx_ready,
	input wire logic bus_addr_valid,
	input wire logic [4:0] bus_addr_in,
	input wire logic addr_hit,
	input wire logic [4:0] bus_addr,
	input wire logic get_in,
	input wire logic srq_req,
	input wire logic trig_pulse,
	input wire logic srq_out,
	input wire logic int_baud_tick,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata
);
	logic queried;
	logic tick_seen;
	int tick_gap;
	shp_pkg::shp_port_t last_port;
	wire logic is_sep;

	// separator bytes or an end indication
	assign is_sep = rx.end_ind || (rx.data inside {`SHP_CH_NL, `SHP_CH_COLON, `SHP_CH_SEMI,
		`SHP_CH_SPACE, `SHP_CH_QMARK});

	// helpers: query seen, last port, cycles since tick
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			queried <= 1'b0;
			tick_seen <= 1'b0;
			tick_gap <= 0;
			last_port <= shp_pkg::SHP_PORT_BUS;
		end
		else
		begin
			queried <= queried || (cmd_valid && cmd.query);
			tick_seen <= tick_seen || int_baud_tick;
			tick_gap <= int_baud_tick ? 0 : tick_gap + 1;
			last_port <= rx_valid ? rx.port : last_port;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	chk_clear_drops_resp: assert property (dev_clear |=> !tx_valid)
		else $error("resp after clear");
	chk_resp_needs_query: assert property ($rose(tx_valid) |-> queried)
		else $error("resp without query");
	chk_resp_held: assert property (tx_valid && !tx_ready && !dev_clear && !rx_valid
		|=> tx_valid && $stable(tx))
		else $error("resp not held");
	chk_cmd_on_sep: assert property ((cmd_valid || cmd_error) |-> $past(rx_valid && is_sep))
		else $error("no separator");
	chk_addr_hit: assert property (addr_hit == ($past(bus_addr_valid)
		&& $past(bus_addr_in) == $past(bus_addr)))
		else $error("addr match wrong");
	chk_trig_bus_only: assert property (trig_pulse |->
		$past(get_in) && $past(last_port) == shp_pkg::SHP_PORT_BUS)
		else $error("trig not bus");
	chk_srq_bus_only: assert property (srq_out |->
		$past(srq_req) && $past(last_port) == shp_pkg::SHP_PORT_BUS)
		else $error("srq not bus");
	chk_tick_period: assert property (int_baud_tick && tick_seen
		|-> tick_gap == CLK_HZ / INT_BAUD - 1)
		else $error("tick period");
	chk_tick_bound: assert property (tick_seen |-> tick_gap < CLK_HZ / INT_BAUD)
		else $error("tick missing");
	chk_rdata_slot: assert property (reg_rdata != 32'h0 |-> $past(reg_rd))
		else $error("rdata slot");

	cov_query: cover property (cmd_valid && cmd.query);
	cov_error: cover property (cmd_error);
	cov_common: cover property (common_valid);
	cov_trig: cover property (trig_pulse);
endmodule

bind shp_header_parser shp_header_parser_properties #(.CLK_HZ(CLK_HZ), .INT_BAUD(INT_BAUD))
	shp_header_parser_properties_inst (.core_clk, .rst_n, .dev_clear, .rx_valid, .rx, .cmd_valid,
	.cmd, .common_valid, .cmd_error, .tx_valid, .tx, .tx_ready, .bus_addr_valid, .bus_addr_in,
	.addr_hit, .bus_addr, .get_in, .srq_req, .trig_pulse, .srq_out, .int_baud_tick, .reg_rd,
	.reg_rdata);

// >>> testbench/shp_ctrl_model.sv
// shp_ctrl_model: controller, sends messages, reads response bytes.
// assumes: parser holds a response byte until tx_ready.
`timescale 1ns/100ps
module shp_ctrl_model (
	input wire logic core_clk,
	input wire logic [1:0] pace,
	output logic rx_valid,
	output shp_pkg::shp_rx_t rx,
	input wire logic tx_valid,
	input wire shp_pkg::shp_resp_t tx,
	output logic tx_ready
);
	int n_got = 0;
	logic [7:0] last_got = 8'h00;
	logic [1:0] cyc = 2'h0;

	initial
	begin
		rx_valid = 1'b0;
		rx = '0;
		tx_ready = 1'b0;
	end

	// pace 0 reads at once, 1 every fourth cycle, 2 never; slow reads test the hold
	always @(posedge core_clk)
	begin
		cyc <= cyc + 2'h1;
		if (tx_valid && tx_ready)
		begin
			n_got <= n_got + 1;
			last_got <= tx.data;
		end
		tx_ready <= (pace == 2'h0) || (pace == 2'h1 && cyc == 2'h3);
	end

	// headers colon joined; idle data inverted so no stale byte lingers
	task automatic send(input string s, input shp_pkg::shp_port_t p, input bit endi);
		for (int i = 0; i < s.len(); i++)
		begin
			@(posedge core_clk);
			rx_valid <= 1'b1;
			rx <= '{p, endi && (i == s.len() - 1), s[i]};
		end
		@(posedge core_clk);
		rx_valid <= 1'b0;
		rx.data <= ~rx.data;
	endtask
endmodule

// >>> testbench/tb_shp_header_parser.sv
// tb_shp_header_parser: directed tests of the parser.
// assumes: package, parser, checker and model compiled first.
`timescale 1ns/100ps
`include "shp_cfg.svh"
module tb_shp_header_parser;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic dev_clear = 1'b0;
	logic resp_in_valid = 1'b0;
	shp_pkg::shp_resp_t resp_in = '0;
	logic bus_addr_valid = 1'b0;
	logic [4:0] bus_addr_in = 5'h00;
	logic fp_addr_we = 1'b0;
	logic [4:0] fp_addr = 5'h00;
	logic get_in = 1'b0;
	logic srq_req = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [1:0] pace = 2'h0;
	logic rx_valid, cmd_valid, common_valid, cmd_error, tx_valid, tx_ready, addr_hit;
	logic trig_pulse, srq_out, int_baud_tick, ser_baud_tick, rx_ready, resp_in_ready;
	shp_pkg::shp_rx_t rx;
	shp_pkg::shp_cmd_t cmd;
	shp_pkg::shp_resp_t tx;
	logic [4:0] bus_addr;
	logic [31:0] reg_rdata, d;
	int num_errors = 0, n_tests = 0, n_cmd = 0, n_err = 0, n_com = 0, n_trig = 0, n_srq = 0;
	int n_hit = 0, c0, e0, k0, t0, s0, k;
	int bauds[5] = '{`SHP_BAUD_9600, `SHP_BAUD_19200, `SHP_BAUD_38400, `SHP_BAUD_57600,
		`SHP_BAUD_115200};

	shp_header_parser shp_header_parser_inst (.core_clk, .rst_n, .dev_clear, .rx_valid, .rx,
		.rx_ready, .cmd_valid, .cmd, .common_valid, .cmd_error, .resp_in_valid, .resp_in,
		.resp_in_ready, .tx_valid, .tx, .tx_ready, .bus_addr_valid, .bus_addr_in, .addr_hit,
		.fp_addr_we, .fp_addr, .bus_addr, .get_in, .srq_req, .trig_pulse, .srq_out,
		.int_baud_tick, .ser_baud_tick, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
	shp_ctrl_model shp_ctrl_model_inst (.core_clk, .pace, .rx_valid, .rx, .tx_valid, .tx,
		.tx_ready);

	always #10 core_clk = ~core_clk;

	// count one-cycle strobes
	always @(posedge core_clk)
	begin
		n_cmd <= n_cmd + (cmd_valid === 1'b1);
		n_err <= n_err + (cmd_error === 1'b1);
		n_com <= n_com + (common_valid === 1'b1);
		n_trig <= n_trig + (trig_pulse === 1'b1);
		n_srq <= n_srq + (srq_out === 1'b1);
		n_hit <= n_hit + (addr_hit === 1'b1);
	end

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmp_n(input int got, input int exp);
		cmp(32'(got), 32'(exp));
	endtask
	task automatic cc(input logic [4:0] n, input logic q);
		cmp({26'h0, cmd}, {26'h0, n, q});
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] v);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task automatic lvl(input logic [4:0] e);
		logic [31:0] v;
		rd(`SHP_REG_STAT, v);
		cmp({27'h0, v[8:4]}, {27'h0, e});
	endtask
	task automatic msg(input string s, input shp_pkg::shp_port_t p = shp_pkg::SHP_PORT_BUS);
		shp_ctrl_model_inst.send(s, p, 1'b0);
		repeat (3) @(posedge core_clk);
	endtask
	task automatic push(input logic [7:0] b);
		@(posedge core_clk);
		resp_in_valid <= 1'b1;
		resp_in <= '{1'b1, b};
		@(posedge core_clk);
		resp_in_valid <= 1'b0;
	endtask
	task automatic pulse_ev;
		@(posedge core_clk);
		get_in <= 1'b1;
		srq_req <= 1'b1;
		@(posedge core_clk);
		get_in <= 1'b0;
		srq_req <= 1'b0;
		repeat (3) @(posedge core_clk);
	endtask
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// watchdog: all tests need about 21000 cycles
	initial
	begin
		repeat (80000) @(posedge core_clk);
		num_errors++;
		final_report();
	end

	initial
	begin
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		rd(`SHP_REG_CTRL, d);
		cmp(d, {24'h0, `SHP_RATE_RST, `SHP_ADDR_RST});
		rd(`SHP_REG_STAT, d);
		cmp(d, 32'h0);
		rd(4'hC, d);
		cmp(d, 32'h0);
		$display("reset done");
		// optional headers, path up, terminator
		c0 = n_cmd;
		e0 = n_err;
		msg("VOLT 1");
		cc(`SHP_N_VLEV, 1'b0);
		lvl(`SHP_N_SOUR);
		msg(";FREQ 60\n");
		cc(`SHP_N_FREQ, 1'b0);
		lvl(`SHP_N_ROOT);
		cmp_n(n_err - e0, 0);
		$display("optional done");
		// lower case walk, sibling after leaf
		msg("sour:volt:rang 1;lev 2", shp_pkg::SHP_PORT_USB);
		cc(`SHP_N_VLEV, 1'b0);
		lvl(`SHP_N_VOLT);
		msg("\n", shp_pkg::SHP_PORT_USB);
		lvl(`SHP_N_ROOT);
		shp_ctrl_model_inst.send("FREQ 5", shp_pkg::SHP_PORT_BUS, 1'b1);
		repeat (3) @(posedge core_clk);
		cc(`SHP_N_FREQ, 1'b0);
		lvl(`SHP_N_ROOT);
		$display("walk done");
		// no tree walking, root colon, errors
		msg("VOLT:RANG 1;FREQ 2\n");
		cmp_n(n_err - e0, 1);
		msg("VOLT:RANG 1;:FREQ 2");
		cc(`SHP_N_FREQ, 1'b0);
		lvl(`SHP_N_SOUR);
		c0 = n_cmd;
		msg("\nXYZ:VOLT 1\n?\n");
		cmp_n(n_cmd - c0, 0);
		cmp_n(n_err - e0, 3);
		rd(`SHP_REG_STAT, d);
		cmp({31'h0, d[0]}, 32'h1);
		$display("errors done");
		// common command keeps the path
		k0 = n_com;
		msg("VOLT:RANG 1;*RST;LEV 2");
		cmp_n(n_com - k0, 1);
		cc(`SHP_N_VLEV, 1'b0);
		cmp_n(n_err - e0, 3);
		msg("\nSOUR:VOLT:");
		lvl(`SHP_N_VOLT);
		@(posedge core_clk);
		dev_clear <= 1'b1;
		@(posedge core_clk);
		dev_clear <= 1'b0;
		lvl(`SHP_N_ROOT);
		$display("common done");
		// query gate, slow reader, interrupt
		push(8'h31);
		repeat (2) @(posedge core_clk);
		cmp({31'h0, tx_valid}, 32'h0);
		k0 = shp_ctrl_model_inst.n_got;
		pace <= 2'h1;
		msg("FREQ?\n");
		cc(`SHP_N_FREQ, 1'b1);
		push(8'h36);
		repeat (12) @(posedge core_clk);
		cmp_n(shp_ctrl_model_inst.n_got - k0, 1);
		cmp({24'h0, shp_ctrl_model_inst.last_got}, 32'h36);
		pace <= 2'h2;
		msg("FREQ?\n");
		push(8'h37);
		msg("VOLT 1\n");
		rd(`SHP_REG_STAT, d);
		cmp({28'h0, d[1], tx_valid, resp_in_ready, rx_ready}, 32'hB);
		pace <= 2'h0;
		wr(`SHP_REG_STAT, 32'h3);
		rd(`SHP_REG_STAT, d);
		cmp({30'h0, d[1:0]}, 32'h0);
		cmp_n(shp_ctrl_model_inst.n_got - k0, 1);
		$display("query done");
		// address by command, panel, match
		wr(`SHP_REG_CTRL, {24'h0, `SHP_RATE_9600, 5'h07});
		rd(`SHP_REG_CTRL, d);
		cmp(d, {24'h0, `SHP_RATE_9600, 5'h07});
		@(posedge core_clk);
		fp_addr_we <= 1'b1;
		fp_addr <= 5'h0A;
		@(posedge core_clk);
		fp_addr_we <= 1'b0;
		@(posedge core_clk);
		cmp({27'h0, bus_addr}, 32'h0A);
		k0 = n_hit;
		bus_addr_valid <= 1'b1;
		bus_addr_in <= 5'h0A;
		@(posedge core_clk);
		bus_addr_in <= 5'h07;
		@(posedge core_clk);
		bus_addr_valid <= 1'b0;
		repeat (2) @(posedge core_clk);
		cmp_n(n_hit - k0, 1);
		$display("address done");
		// bus-only events
		t0 = n_trig;
		s0 = n_srq;
		msg("\n", shp_pkg::SHP_PORT_LAN);
		pulse_ev();
		cmp_n(n_trig - t0 + n_srq - s0, 0);
		msg("\n");
		pulse_ev();
		cmp_n(n_trig - t0, 1);
		cmp_n(n_srq - s0, 1);
		$display("bus events done");
		// each serial rate: tick gap is clock over rate
		for (int r = 0; r < 5; r++)
		begin
			wr(`SHP_REG_CTRL, {24'h0, 3'(r), 5'h0A});
			for (int j = 0; j < 2; j++)
			begin
				k = 0;
				@(negedge core_clk);
				while (ser_baud_tick !== 1'b1 && k < 6000)
				begin
					@(negedge core_clk);
					k++;
				end
			end
			cmp_n(int'(k >= 50000000 / bauds[r] - 2 && k <= 50000000 / bauds[r]), 1);
		end
		$display("rates done");
		final_report();
	end
endmodule
